// ---- hw/cmc_cfg.svh ----
// Constants of the comparator control block: offsets, fields, reset values, counts
// Operation
// - Comparator runs only while enable set
// - Result readable in control A and summary
// - Result latched once per instruction cycle
// - Invert bit complements the comparison result
// - Hysteresis output follows hysteresis enable bit
// - Result offered as timer gate source
// - Sync bit relatches on timer falling edge
// - Enabled rising or falling edge sets flag
// - Hardware set wins over software clear
// - Invert or enable toggles also raise edges
// - Positive select field routes noninverting input
// - Negative select field routes inverting input
// - Disabled comparator disconnects all inputs
// - Port read returns zero for analog pins
// - Result plus enable shuts waveform generator
// - Synced output stops in sleep on system clocks
// - Flag with interrupt enable wakes device
// - Hysteresis enable at control A bit one
`ifndef CMC_CFG_SVH
`define CMC_CFG_SVH

// Register byte offsets
`define CMC_OFS_CTRL_A      8'h00
`define CMC_OFS_CTRL_B      8'h04
`define CMC_OFS_SUMMARY     8'h08
`define CMC_OFS_IRQ         8'h0c
`define CMC_OFS_ANALOG_SELECT       8'h10
`define CMC_OFS_DIR         8'h14
`define CMC_OFS_PORT        8'h18
`define CMC_OFS_PINSEL      8'h1c
`define CMC_OFS_MISC        8'h20

// Control register A fields
`define CMC_A_ENABLE        7
`define CMC_A_RESULT        6
`define CMC_A_INVERT        4
`define CMC_A_SPEED         2
`define CMC_A_HYST          1
`define CMC_A_SYNC          0

// Control register B fields
`define CMC_B_RISE          7
`define CMC_B_FALL          6
`define CMC_B_PSEL_HI       5
`define CMC_B_PSEL_LO       3
`define CMC_B_NSEL_HI       2
`define CMC_B_NSEL_LO       0

// Interrupt register and misc register fields
`define CMC_IRQ_FLAG        0
`define CMC_IRQ_ENABLE      1
`define CMC_MISC_SHDN_EN    0
`define CMC_MISC_TCLK_SYS   1

// Reset values
`define CMC_RST_SPEED       1'b1
`define CMC_RST_BYTE        8'h00
`define CMC_RST_DIR         8'hff

// Last divider count of the instruction cycle, which is four system clocks
`define CMC_INSTR_CLKS      2'h3

`endif

// ---- hw/cmc_edge.sv ----
// Rise and fall pulse detector sampled on instruction ticks
`timescale 1ns/1ps
module cmc_edge (
    input  wire logic mclk_i,
    input  wire logic rst_n_i,
    input  wire logic tick_i,
    input  wire logic d_i,
    output logic      rise_o,
    output logic      fall_o
);
    cmc_pkg::cmc_edge_st_t s_q;
    cmc_pkg::cmc_edge_st_t s_d;

    // Compare with the previous tick sample, one pulse per change
    always_comb begin
        s_d      = s_q;
        s_d.rise = 1'b0;
        s_d.fall = 1'b0;
        if (tick_i) begin
            s_d.prev = d_i;
            s_d.rise = d_i & ~s_q.prev;
            s_d.fall = ~d_i & s_q.prev;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rise_o = s_q.rise;
    assign fall_o = s_q.fall;
endmodule

// ---- hw/cmc_pkg.sv ----
// Types shared by the comparator control block
package cmc_pkg;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } cmc_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } cmc_apb_rsp_t;

    typedef struct packed {
        logic       power;
        logic       hyst;
        logic       speed;
        logic       connect;
        logic [2:0] pos_sel;
        logic [2:0] neg_sel;
    } cmc_ana_t;

    typedef struct packed {
        logic prev;
        logic rise;
        logic fall;
    } cmc_edge_st_t;

    typedef struct packed {
        logic clk_prev;
        logic out;
    } cmc_tsync_st_t;

    // Bus handshake phases, Gray coded
    typedef enum logic [1:0] {
        CMC_BUS_IDLE = 2'b00,
        CMC_BUS_ACK  = 2'b01
    } cmc_bus_t;

    typedef struct packed {
        cmc_bus_t     bus;
        logic [1:0]   div;
        logic         tick;
        logic         res_now;
        logic         res_lat;
        logic         ena;
        logic         inv;
        logic         speed;
        logic         hyst;
        logic         sync;
        logic         rise_en;
        logic         fall_en;
        logic [2:0]   psel;
        logic [2:0]   nsel;
        logic         flag;
        logic         ie;
        logic [7:0]   analog_select;
        logic [7:0]   dir;
        logic [7:0]   pinsel;
        logic         shdn_en;
        logic         tclk_sys;
        cmc_apb_rsp_t rsp;
        cmc_ana_t     ana;
        logic         shutdown;
        logic [7:0]   pin_out;
        logic [7:0]   pin_oe;
        logic         irq;
        logic         wake;
    } cmc_state_t;

endpackage

// ---- hw/cmc_top.sv ----
// Comparator control and status logic with APB register access
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "cmc_cfg.svh"
module cmc_top (
    input  wire logic                  mclk_i,
    input  wire logic                  rstn_i,
    input  wire cmc_pkg::cmc_apb_req_t apb_i,
    output cmc_pkg::cmc_apb_rsp_t      apb_o,
    input  wire logic                  cmp_raw_i,
    input  wire logic                  tmr_clk_i,
    input  wire logic                  sleep_i,
    input  wire logic [7:0]            pin_i,
    output cmc_pkg::cmc_ana_t          ana_o,
    output logic                       tmr_gate_o,
    output logic                       shutdown_o,
    output logic [7:0]                 pin_o,
    output logic [7:0]                 pin_oe_o,
    output logic                       irq_o,
    output logic                       wake_o
);
    logic [1:0]          rst_sync_q;
    logic                rst_n;
    cmc_pkg::cmc_state_t s_q;
    cmc_pkg::cmc_state_t s_d;
    logic                rise;
    logic                fall;
    logic                res_sync;
    logic                bus_wr;
    logic                bus_rd;
    logic [7:0]          wbyte;
    logic [31:0]         rdata;
    logic                hit;

    // Reset release through two flops, assertion stays asynchronous
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    // Edge detection on the latched result
    cmc_edge i_cmc_edge (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n),
        .tick_i  (s_q.tick),
        .d_i     (s_q.res_lat),
        .rise_o  (rise),
        .fall_o  (fall)
    );

    // Timer facing copy; with sync set, frozen in sleep when the timer runs on system clocks
    cmc_tsync i_cmc_tsync (
        .mclk_i    (mclk_i),
        .rst_n_i   (rst_n),
        .tmr_clk_i (tmr_clk_i),
        .d_i       (s_q.res_now),
        .sync_i    (s_q.sync),
        .hold_i    (sleep_i & s_q.tclk_sys),
        .q_o       (res_sync)
    );

    // Write takes effect on the edge where pready is seen high; read data is registered one edge earlier
    assign bus_wr = apb_i.psel & apb_i.penable & apb_i.pwrite & (s_q.bus == cmc_pkg::CMC_BUS_ACK);
    assign bus_rd = apb_i.psel & apb_i.penable & ~apb_i.pwrite;
    assign wbyte  = apb_i.pwdata[7:0];

    // Read mux, narrow registers sit in the low byte
    always_comb begin
        rdata = 32'h0;
        hit   = 1'b1;
        unique case (apb_i.paddr)
            `CMC_OFS_CTRL_A: begin
                rdata[`CMC_A_ENABLE] = s_q.ena;
                rdata[`CMC_A_RESULT] = s_q.res_lat;
                rdata[`CMC_A_INVERT] = s_q.inv;
                rdata[`CMC_A_SPEED]  = s_q.speed;
                rdata[`CMC_A_HYST]   = s_q.hyst;
                rdata[`CMC_A_SYNC]   = s_q.sync;
            end
            `CMC_OFS_CTRL_B: begin
                rdata[`CMC_B_RISE] = s_q.rise_en;
                rdata[`CMC_B_FALL] = s_q.fall_en;
                rdata[`CMC_B_PSEL_HI:`CMC_B_PSEL_LO] = s_q.psel;
                rdata[`CMC_B_NSEL_HI:`CMC_B_NSEL_LO] = s_q.nsel;
            end
            `CMC_OFS_SUMMARY: begin
                rdata[0] = s_q.res_lat;
            end
            `CMC_OFS_IRQ: begin
                rdata[`CMC_IRQ_FLAG]   = s_q.flag;
                rdata[`CMC_IRQ_ENABLE] = s_q.ie;
            end
            `CMC_OFS_ANALOG_SELECT: begin
                rdata[7:0] = s_q.analog_select;
            end
            `CMC_OFS_DIR: begin
                rdata[7:0] = s_q.dir;
            end
            `CMC_OFS_PORT: begin
                rdata[7:0] = pin_i & ~s_q.analog_select;
            end
            `CMC_OFS_PINSEL: begin
                rdata[7:0] = s_q.pinsel;
            end
            `CMC_OFS_MISC: begin
                rdata[`CMC_MISC_SHDN_EN]  = s_q.shdn_en;
                rdata[`CMC_MISC_TCLK_SYS] = s_q.tclk_sys;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // Next state of the whole block
    always_comb begin
        s_d = s_q;

        // Instruction cycle tick, one in every four system clocks
        s_d.div  = s_q.div + 2'h1;
        s_d.tick = (s_q.div == `CMC_INSTR_CLKS);

        // Disabled core reads as low before the invert stage
        s_d.res_now = (s_q.ena & cmp_raw_i) ^ s_q.inv;
        if (s_q.tick) begin
            s_d.res_lat = s_q.res_now;
        end

        // Bus handshake: one wait state, then pready for one cycle
        s_d.rsp.pready  = 1'b0;
        s_d.rsp.pslverr = 1'b0;
        unique case (s_q.bus)
            cmc_pkg::CMC_BUS_IDLE: begin
                if (apb_i.psel && apb_i.penable) begin
                    s_d.bus         = cmc_pkg::CMC_BUS_ACK;
                    s_d.rsp.pready  = 1'b1;
                    s_d.rsp.pslverr = ~hit;
                    s_d.rsp.prdata  = bus_rd ? rdata : 32'h0;
                end
            end
            cmc_pkg::CMC_BUS_ACK: begin
                s_d.bus = cmc_pkg::CMC_BUS_IDLE;
            end
            default: begin
                s_d.bus = cmc_pkg::CMC_BUS_IDLE;
            end
        endcase

        // Register writes
        if (bus_wr) begin
            unique case (apb_i.paddr)
                `CMC_OFS_CTRL_A: begin
                    s_d.ena   = wbyte[`CMC_A_ENABLE];
                    s_d.inv   = wbyte[`CMC_A_INVERT];
                    s_d.speed = wbyte[`CMC_A_SPEED];
                    s_d.hyst  = wbyte[`CMC_A_HYST];
                    s_d.sync  = wbyte[`CMC_A_SYNC];
                end
                `CMC_OFS_CTRL_B: begin
                    s_d.rise_en = wbyte[`CMC_B_RISE];
                    s_d.fall_en = wbyte[`CMC_B_FALL];
                    s_d.psel    = wbyte[`CMC_B_PSEL_HI:`CMC_B_PSEL_LO];
                    s_d.nsel    = wbyte[`CMC_B_NSEL_HI:`CMC_B_NSEL_LO];
                end
                `CMC_OFS_IRQ: begin
                    // Flag can only be cleared, writing one leaves it alone
                    if (!wbyte[`CMC_IRQ_FLAG]) begin
                        s_d.flag = 1'b0;
                    end
                    s_d.ie = wbyte[`CMC_IRQ_ENABLE];
                end
                `CMC_OFS_ANALOG_SELECT: begin
                    s_d.analog_select = wbyte;
                end
                `CMC_OFS_DIR: begin
                    s_d.dir = wbyte;
                end
                `CMC_OFS_PINSEL: begin
                    s_d.pinsel = wbyte;
                end
                `CMC_OFS_MISC: begin
                    s_d.shdn_en  = wbyte[`CMC_MISC_SHDN_EN];
                    s_d.tclk_sys = wbyte[`CMC_MISC_TCLK_SYS];
                end
                default: begin
                end
            endcase
        end

        // Qualified edges set the flag after any clear, so a set wins
        if ((rise && s_q.rise_en) || (fall && s_q.fall_en)) begin
            s_d.flag = 1'b1;
        end

        // Analog controls; selections are masked while disabled
        s_d.ana.power   = s_q.ena;
        s_d.ana.hyst    = s_q.hyst;
        s_d.ana.speed   = s_q.speed;
        s_d.ana.connect = s_q.ena;
        s_d.ana.pos_sel = s_q.ena ? s_q.psel : 3'h0;
        s_d.ana.neg_sel = s_q.ena ? s_q.nsel : 3'h0;

        // Unlatched result straight to the generator shutdown path
        s_d.shutdown = s_q.shdn_en & s_q.res_now;

        // Pin driver follows selection and direction set by software
        s_d.pin_oe  = s_q.pinsel & ~s_q.dir;
        s_d.pin_out = s_q.pinsel & {8{res_sync}};

        // Interrupt request and wake from sleep
        s_d.irq  = s_q.flag & s_q.ie;
        s_d.wake = s_q.flag & s_q.ie & sleep_i;
    end

    // Whole state registered on one process
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            s_q          <= '0;
            s_q.bus      <= cmc_pkg::CMC_BUS_IDLE;
            s_q.speed    <= `CMC_RST_SPEED;
            s_q.analog_select    <= `CMC_RST_BYTE;
            s_q.dir      <= `CMC_RST_DIR;
            s_q.pinsel   <= `CMC_RST_BYTE;
        end else begin
            s_q <= s_d;
        end
    end

    // Ports come straight from state flops
    assign apb_o      = s_q.rsp;
    assign ana_o      = s_q.ana;
    assign tmr_gate_o = res_sync;
    assign shutdown_o = s_q.shutdown;
    assign pin_o      = s_q.pin_out;
    assign pin_oe_o   = s_q.pin_oe;
    assign irq_o      = s_q.irq;
    assign wake_o     = s_q.wake;
endmodule

// ---- hw/cmc_tsync.sv ----
// Result relatch on the falling edge of the timer clock
`timescale 1ns/1ps
module cmc_tsync (
    input  wire logic mclk_i,
    input  wire logic rst_n_i,
    input  wire logic tmr_clk_i,
    input  wire logic d_i,
    input  wire logic sync_i,
    input  wire logic hold_i,
    output logic      q_o
);
    cmc_pkg::cmc_tsync_st_t s_q;
    cmc_pkg::cmc_tsync_st_t s_d;

    // Timer clock is sampled as a plain synchronous input
    always_comb begin
        s_d          = s_q;
        s_d.clk_prev = tmr_clk_i;
        if (!sync_i) begin
            s_d.out = d_i;
        end else if (hold_i) begin
            s_d.out = s_q.out;
        end else if (s_q.clk_prev && !tmr_clk_i) begin
            s_d.out = d_i;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign q_o = s_q.out;
endmodule

// ---- tb/cmc_top_properties.sv ----
// Port-level checks for the comparator control block
`timescale 1ns/1ps
module cmc_top_properties (
    input wire logic                  mclk_i,
    input wire logic                  rstn_i,
    input wire cmc_pkg::cmc_apb_req_t apb_i,
    input wire cmc_pkg::cmc_apb_rsp_t apb_o,
    input wire logic                  sleep_i,
    input wire cmc_pkg::cmc_ana_t     ana_o,
    input wire logic                  irq_o,
    input wire logic                  wake_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    // Completed write to the interrupt register
    logic wr_irq;
    assign wr_irq = apb_i.psel && apb_i.penable && apb_i.pwrite && apb_o.pready
                    && apb_i.paddr == 8'h0c;

    property p_ready_pulse;
        apb_o.pready |=> !apb_o.pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held two cycles");
    // One wait state, so the answer comes exactly one edge late
    property p_wait_state;
        apb_i.psel && !apb_i.penable ##1 apb_i.psel && apb_i.penable
            |-> !apb_o.pready ##1 apb_o.pready;
    endproperty
    a_wait_state: assert property (p_wait_state) else $error("ready timing wrong");
    property p_err_map;
        apb_o.pready && apb_i.paddr[1:0] == 2'b00 |-> apb_o.pslverr == (apb_i.paddr > 8'h20);
    endproperty
    a_err_map: assert property (p_err_map) else $error("error response wrong");
    property p_err_ready;
        apb_o.pslverr |-> apb_o.pready;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    property p_rd_width;
        apb_o.pready && !apb_i.pwrite |-> apb_o.prdata[31:8] == 24'h0;
    endproperty
    a_rd_width: assert property (p_rd_width) else $error("upper read bits set");
    property p_disconnect;
        !ana_o.power |-> !ana_o.connect && ana_o.pos_sel == 3'h0 && ana_o.neg_sel == 3'h0;
    endproperty
    a_disconnect: assert property (p_disconnect) else $error("inputs live while off");
    property p_wake;
        !$past(sleep_i) |-> !wake_o;
    endproperty
    a_wake: assert property (p_wake) else $error("wake while awake");
    // Flag only drops after software clears it
    property p_irq_clear;
        $fell(irq_o) |-> $past(wr_irq) || $past(wr_irq, 2) || $past(wr_irq, 3);
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("flag dropped alone");

    cover property (apb_o.pslverr);
    cover property ($rose(irq_o));
    cover property (wake_o);
endmodule

bind cmc_top cmc_top_properties i_cmc_top_properties (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .apb_i(apb_i), .apb_o(apb_o),
    .sleep_i(sleep_i), .ana_o(ana_o), .irq_o(irq_o), .wake_o(wake_o));

// ---- tb/cmc_top_tb_top.sv ----
// Directed register-level bench for the comparator control block
`timescale 1ns/1ps
module cmc_top_tb_top;
    logic                  mclk_i;
    logic                  rstn_i;
    cmc_pkg::cmc_apb_req_t apb_i;
    cmc_pkg::cmc_apb_rsp_t apb_o;
    logic                  cmp_raw_i;
    logic                  tmr_clk_i;
    logic                  sleep_i;
    logic [7:0]            pin_i;
    cmc_pkg::cmc_ana_t     ana_o;
    logic                  tmr_gate_o;
    logic                  shutdown_o;
    logic [7:0]            pin_o;
    logic [7:0]            pin_oe_o;
    logic                  irq_o;
    logic                  wake_o;
    logic [31:0]           rd;
    logic                  err;
    int                    n_fail;
    int                    total_checks;
    logic [7:0]            ra [7] = '{8'h00, 8'h04, 8'h0c, 8'h10, 8'h14, 8'h1c, 8'h20};
    logic [7:0]            rv [7] = '{8'h04, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00};

    cmc_top i_cmc_top (
        .mclk_i(mclk_i), .rstn_i(rstn_i), .apb_i(apb_i), .apb_o(apb_o),
        .cmp_raw_i(cmp_raw_i), .tmr_clk_i(tmr_clk_i), .sleep_i(sleep_i),
        .pin_i(pin_i), .ana_o(ana_o), .tmr_gate_o(tmr_gate_o),
        .shutdown_o(shutdown_o), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
        .irq_o(irq_o), .wake_o(wake_o));

    // System clock, 8 ns period
    initial begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
    endtask

    // One transfer; the leading idle edge keeps calls from double-driving
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge mclk_i);
        apb_i <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge mclk_i);
        apb_i.penable <= 1'b1;
        for (k = 0; k < 16; k++) begin
            @(posedge mclk_i);
            if (apb_o.pready === 1'b1) break;
        end
        if (k == 16) begin
            n_fail++;
            finish_test();
        end
        rd = apb_o.prdata;
        err = apb_o.pslverr;
        apb_i <= '0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(rd, x);
    endtask

    // Long settle covers the instruction-tick latch and edge pipeline
    task automatic raw(input logic v);
        @(posedge mclk_i);
        cmp_raw_i <= v;
        cyc(16);
    endtask

    // Main sequence
    initial begin
        rstn_i = 1'b0;
        apb_i = '0;
        cmp_raw_i = 1'b0;
        tmr_clk_i = 1'b1;
        sleep_i = 1'b0;
        pin_i = 8'h00;
        n_fail = 0;
        total_checks = 0;
        cyc(2);
        rstn_i <= 1'b1;
        cyc(3);
        foreach (ra[i]) rchk(ra[i], {24'h0, rv[i]});
        rchk(8'h40, 32'h0);
        chk(err, 1'b1);
        apb(1'b1, 8'h08, 32'hff);
        rchk(8'h08, 32'h0);
        apb(1'b1, 8'h04, 32'hea);
        cyc(2);
        chk({ana_o.connect, ana_o.pos_sel, ana_o.neg_sel}, 7'h00);
        apb(1'b1, 8'h00, 32'h86);
        cyc(2);
        chk(ana_o, 10'h3ea);
        apb(1'b1, 8'h0c, 32'h02);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 8'h00, {24'h0, 3'b100, i[1], 4'h6});
            raw(i[0]);
            rchk(8'h00, {24'h0, 1'b1, i[0] ^ i[1], 1'b0, i[1], 4'h6});
            rchk(8'h08, {31'h0, i[0] ^ i[1]});
        end
        apb(1'b1, 8'h0c, 32'h02);
        apb(1'b1, 8'h04, 32'h6a);
        raw(1'b0);
        rchk(8'h0c, 32'h02);
        raw(1'b1);
        rchk(8'h0c, 32'h03);
        chk(irq_o, 1'b1);
        @(posedge mclk_i);
        sleep_i <= 1'b1;
        cyc(3);
        chk(wake_o, 1'b1);
        sleep_i <= 1'b0;
        apb(1'b1, 8'h0c, 32'h02);
        cyc(2);
        chk(irq_o, 1'b0);
        // Disabled comparator still flags invert and enable toggles
        apb(1'b1, 8'h04, 32'hea);
        apb(1'b1, 8'h00, 32'h16);
        cyc(16);
        rchk(8'h0c, 32'h03);
        chk(ana_o.power, 1'b0);
        apb(1'b1, 8'h0c, 32'h02);
        apb(1'b1, 8'h00, 32'h06);
        cyc(16);
        rchk(8'h0c, 32'h03);
        apb(1'b1, 8'h0c, 32'h02);
        apb(1'b1, 8'h10, 32'h0f);
        pin_i <= 8'h5a;
        rchk(8'h18, 32'h50);
        apb(1'b1, 8'h1c, 32'h03);
        apb(1'b1, 8'h14, 32'hfe);
        apb(1'b1, 8'h20, 32'h01);
        apb(1'b1, 8'h00, 32'h84);
        cyc(16);
        chk(pin_oe_o, 8'h01);
        chk(pin_o[0], 1'b1);
        chk(shutdown_o, 1'b1);
        chk(tmr_gate_o, 1'b1);
        raw(1'b0);
        chk(shutdown_o, 1'b0);
        chk(tmr_gate_o, 1'b0);
        raw(1'b1);
        // Synced gate waits for a timer clock fall
        apb(1'b1, 8'h00, 32'h85);
        raw(1'b0);
        chk(tmr_gate_o, 1'b1);
        tmr_clk_i <= 1'b0;
        cyc(4);
        chk(tmr_gate_o, 1'b0);
        apb(1'b1, 8'h20, 32'h03);
        sleep_i <= 1'b1;
        tmr_clk_i <= 1'b1;
        raw(1'b1);
        tmr_clk_i <= 1'b0;
        cyc(8);
        chk(tmr_gate_o, 1'b0);
        finish_test();
    end
endmodule
